/* File: inc/radio_link_setup_defines.svh */
`ifndef RADIO_LINK_SETUP_DEFINES_SVH
`define RADIO_LINK_SETUP_DEFINES_SVH

// register offsets
`define ADDR_WIDTH_SETUP_OFS 5'h03
`define RESEND_SETUP_OFS 5'h04
`define RADIO_CHANNEL_SEL_OFS 5'h05
`define RADIO_SETUP_OFS 5'h06

// reset values
`define ADDR_WIDTH_RST 2'h3
`define RESEND_SETUP_RST 8'h03
`define RADIO_CHANNEL_RST 7'h02
`define RADIO_SETUP_RST 8'h0E
// per-field resets, since a literal cannot be bit-selected
`define CARRIER_RST 1'b0
`define LOW_RATE_RST 1'b0
`define PLL_FORCE_RST 1'b0
`define HIGH_RATE_RST 1'b1
`define PWR_RST 2'h3
`define RLIMIT_RST 4'h3
`define RDELAY_RST 4'h0

// field positions
`define AW_HI 1
`define AW_LO 0
`define RDELAY_HI 7
`define RDELAY_LO 4
`define RLIMIT_HI 3
`define RLIMIT_LO 0
`define CHAN_HI 6
`define CHAN_LO 0
`define CARRIER_BIT 7
`define LOW_RATE_BIT 5
`define PLL_FORCE_BIT 4
`define HIGH_RATE_BIT 3
`define PWR_HI 2
`define PWR_LO 1
`define STAT_RETRY_BIT 4

// field values
`define AW_ILLEGAL 2'h0
`define AW_3B 2'h1
`define AW_4B 2'h2
`define AW_5B 2'h3
`define LANES_3B 5'h07
`define LANES_4B 5'h0F
`define LANES_5B 5'h1F
`define WIDTH_3B 3'h3
`define WIDTH_4B 3'h4
`define WIDTH_5B 3'h5

// spi command decode
`define CMD_OP_HI 7
`define CMD_OP_LO 5
`define CMD_READ_OP 3'h0
`define CMD_WRITE_OP 3'h1
`define CMD_ADDR_HI 4
`define CMD_ADDR_LO 0
`define BIT_CNT_LAST 3'h7

// retransmit timing
`define RETX_STEP_US 250
`define CLK_MHZ 200

`endif

/* File: inc/radio_link_setup_pkg.sv */
package radio_link_setup_pkg;

   typedef enum logic [2:0] {
      SPI_IDLE = 3'b001,
      SPI_CMD = 3'b010,
      SPI_DATA = 3'b100
   } spi_state_t;

   typedef enum logic [1:0] {
      RT_IDLE = 2'b01,
      RT_WAIT = 2'b10
   } retx_state_t;

   typedef enum logic [1:0] {
      RATE_1M = 2'b00,
      RATE_2M = 2'b01,
      RATE_250K = 2'b10
   } data_rate_t;

   typedef struct packed {
      logic [2:0] address_width;
      logic [4:0] addr_lane_en;
      logic [6:0] radio_channel;
      logic carrier_only_tx;
      logic pll_lock_force;
      data_rate_t data_rate;
      logic [1:0] tx_power_level;
   } link_cfg_t;

endpackage : radio_link_setup_pkg

/* File: logic/retransmit_ctrl.sv */
`timescale 1ns/1ps
`include "radio_link_setup_defines.svh"

module retransmit_ctrl
   import radio_link_setup_pkg::*;
#(
   parameter logic [19:0] STEP_CYCLES = 20'd50000
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // settings
   input wire logic [3:0] retransmit_limit,
   input wire logic [3:0] retransmit_delay,
   // engine events
   input wire logic packet_start,
   input wire logic ack_missed,
   input wire logic ack_ok,
   input wire logic flag_clr,
   // results
   output logic retx_start,
   output logic [3:0] retx_count,
   output logic retry_exhausted_flag,
   output logic retx_waiting
);

   retx_state_t state_ff;
   logic [19:0] wait_ff;
   logic give_up;
   logic try_again;

   function automatic logic [19:0] delay_cycles(input logic [3:0] code);
      delay_cycles = 20'((code + 5'h01) * STEP_CYCLES);
   endfunction : delay_cycles

   // flag blocks any further attempt until cleared
   assign give_up = ack_missed && !retry_exhausted_flag &&
                    retx_count >= retransmit_limit;
   assign try_again = ack_missed && !retry_exhausted_flag &&
                      retx_count < retransmit_limit;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= RT_IDLE;
         wait_ff <= 20'h00000;
         retx_start <= 1'b0;
      end else if (ce) begin
         retx_start <= 1'b0;
         case (state_ff)
            RT_IDLE: begin
               if (try_again) begin
                  state_ff <= RT_WAIT;
                  wait_ff <= delay_cycles(retransmit_delay);
               end
            end
            RT_WAIT: begin
               if (ack_ok || packet_start) begin
                  state_ff <= RT_IDLE;
               end else if (wait_ff <= 20'h00001) begin
                  state_ff <= RT_IDLE;
                  retx_start <= 1'b1;
               end else begin
                  wait_ff <= wait_ff - 20'h00001;
               end
            end
            default: state_ff <= RT_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         retx_count <= 4'h0;
      end else if (ce) begin
         if (packet_start) begin
            retx_count <= 4'h0;
         end else if (try_again) begin
            retx_count <= retx_count + 4'h1;
         end
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         retry_exhausted_flag <= 1'b0;
      end else if (ce) begin
         if (give_up) begin
            retry_exhausted_flag <= 1'b1;
         end else if (flag_clr) begin
            retry_exhausted_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         retx_waiting <= 1'b0;
      end else if (ce) begin
         retx_waiting <= (state_ff == RT_WAIT);
      end
   end

endmodule : retransmit_ctrl

/* File: logic/radio_link_setup_regs.sv */
// Functional notes
// - address width code: 01/10/11 = 3/4/5 bytes
// - narrower widths use low address bytes only
// - one width for all pipes and transmit
// - retransmit delay 250us steps up to 4000us
// - retransmit limit field, resets to three
// - seven-bit channel field, resets to two
// - carrier bit sends unmodulated carrier, resets zero
// - rate bits; high bit ignored when low set
// - pll-lock bit forces lock indication, test only
// - power code 00..11 = -18..0 dBm, reset 11
// - registers reached only through spi commands
// - undefined bit positions read as zero
// - exhausted retries raise flag, cleared before resume
`timescale 1ns/1ps
`include "radio_link_setup_defines.svh"

module radio_link_setup_regs
   import radio_link_setup_pkg::*;
#(
   parameter logic [19:0] RETX_STEP_CYCLES =
      20'(`RETX_STEP_US * `CLK_MHZ)
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // spi register port from the microcontroller
   input wire logic spi_sck,
   input wire logic spi_csn_b,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // protocol engine events
   input wire logic packet_start,
   input wire logic ack_missed,
   input wire logic ack_ok,
   input wire logic retry_flag_clr,
   // settings to the radio
   output link_cfg_t link_cfg,
   output logic [3:0] retransmit_limit,
   output logic [3:0] retransmit_delay,
   // retransmit results
   output logic retx_start,
   output logic [3:0] retx_count,
   output logic retry_exhausted_flag,
   output logic retx_waiting
);

   ////////////////////////////////////////////////////////////////////////
   // storage

   logic [1:0] address_width_ff;
   logic [7:0] resend_setup_ff;
   logic [6:0] radio_channel_ff;
   logic carrier_only_tx_ff;
   logic low_rate_select_ff;
   logic pll_lock_force_ff;
   logic high_rate_select_ff;
   logic [1:0] tx_power_level_ff;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // reserved positions are not stored, so they always read zero
   function automatic logic [7:0] read_reg(input logic [4:0] ofs);
      read_reg = 8'h00;
      case (ofs)
         `ADDR_WIDTH_SETUP_OFS: begin
            read_reg[`AW_HI:`AW_LO] = address_width_ff;
         end
         `RESEND_SETUP_OFS: begin
            read_reg = resend_setup_ff;
         end
         `RADIO_CHANNEL_SEL_OFS: begin
            read_reg[`CHAN_HI:`CHAN_LO] = radio_channel_ff;
         end
         `RADIO_SETUP_OFS: begin
            read_reg[`CARRIER_BIT] = carrier_only_tx_ff;
            read_reg[`LOW_RATE_BIT] = low_rate_select_ff;
            read_reg[`PLL_FORCE_BIT] = pll_lock_force_ff;
            read_reg[`HIGH_RATE_BIT] = high_rate_select_ff;
            read_reg[`PWR_HI:`PWR_LO] = tx_power_level_ff;
         end
         default: read_reg = 8'h00;
      endcase
   endfunction : read_reg

   function automatic logic [4:0] lanes_of(input logic [2:0] width);
      case (width)
         `WIDTH_3B: lanes_of = `LANES_3B;
         `WIDTH_4B: lanes_of = `LANES_4B;
         default: lanes_of = `LANES_5B;
      endcase
   endfunction : lanes_of

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [1:0] sck_sync_ff;
   logic [1:0] csn_sync_ff;
   logic [1:0] mosi_sync_ff;
   logic sck_last_ff;
   logic csn_last_ff;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sck_sync_ff <= 2'h0;
         csn_sync_ff <= 2'h3;
         mosi_sync_ff <= 2'h0;
         sck_last_ff <= 1'b0;
         csn_last_ff <= 1'b1;
      end else if (ce) begin
         sck_sync_ff <= {sck_sync_ff[0], spi_sck};
         csn_sync_ff <= {csn_sync_ff[0], spi_csn_b};
         mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
         sck_last_ff <= sck_sync_ff[1];
         csn_last_ff <= csn_sync_ff[1];
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic frame_open;
   logic frame_begin;

   assign frame_open = !csn_sync_ff[1];
   assign frame_begin = frame_open && csn_last_ff;
   assign sck_rise = frame_open && sck_sync_ff[1] && !sck_last_ff;
   assign sck_fall = frame_open && !sck_sync_ff[1] && sck_last_ff;

   ////////////////////////////////////////////////////////////////////////
   // spi command engine

   spi_state_t spi_state_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] rx_shift_ff;
   logic [7:0] tx_shift_ff;
   logic [4:0] cmd_addr_ff;
   logic cmd_write_ff;
   logic [7:0] rx_byte;
   logic byte_done;
   logic [7:0] status_byte;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;

   assign rx_byte = {rx_shift_ff[6:0], mosi_sync_ff[1]};
   assign byte_done = sck_rise && (bit_cnt_ff == `BIT_CNT_LAST);

   always_comb begin
      status_byte = 8'h00;
      status_byte[`STAT_RETRY_BIT] = retry_exhausted_flag;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         spi_state_ff <= SPI_IDLE;
         bit_cnt_ff <= 3'h0;
         rx_shift_ff <= 8'h00;
         cmd_addr_ff <= 5'h00;
         cmd_write_ff <= 1'b0;
      end else if (ce) begin
         case (spi_state_ff)
            SPI_IDLE: begin
               if (frame_begin) begin
                  spi_state_ff <= SPI_CMD;
                  bit_cnt_ff <= 3'h0;
               end
            end
            SPI_CMD: begin
               if (!frame_open) begin
                  spi_state_ff <= SPI_IDLE;
               end else if (sck_rise) begin
                  rx_shift_ff <= rx_byte;
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (byte_done) begin
                     spi_state_ff <= SPI_DATA;
                     cmd_addr_ff <= rx_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
                     cmd_write_ff <= rx_byte[`CMD_OP_HI:`CMD_OP_LO] ==
                                     `CMD_WRITE_OP;
                  end
               end
            end
            SPI_DATA: begin
               if (!frame_open) begin
                  spi_state_ff <= SPI_IDLE;
                  cmd_write_ff <= 1'b0;
               end else if (sck_rise) begin
                  rx_shift_ff <= rx_byte;
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
               end
            end
            default: spi_state_ff <= SPI_IDLE;
         endcase
      end
   end

   // other opcodes belong to other blocks; only writes land here
   assign wr_en = (spi_state_ff == SPI_DATA) && byte_done &&
                  cmd_write_ff;
   assign wr_addr = cmd_addr_ff;
   assign wr_data = rx_byte;

   // miso changes on the falling edge, sampled by the master on rising
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_shift_ff <= 8'h00;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else if (ce) begin
         spi_miso_oe <= frame_open;
         if (frame_begin) begin
            spi_miso <= status_byte[7];
            tx_shift_ff <= {status_byte[6:0], 1'b0};
         end else if (byte_done) begin
            if (spi_state_ff == SPI_CMD) begin
               tx_shift_ff <= read_reg(rx_byte[`CMD_ADDR_HI:`CMD_ADDR_LO]);
            end else begin
               tx_shift_ff <= read_reg(cmd_addr_ff);
            end
         end else if (sck_fall) begin
            spi_miso <= tx_shift_ff[7];
            tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   // reserved bits written by software are dropped here
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         address_width_ff <= `ADDR_WIDTH_RST;
      end else if (ce && wr_en && wr_addr == `ADDR_WIDTH_SETUP_OFS) begin
         address_width_ff <= wr_data[`AW_HI:`AW_LO];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         resend_setup_ff <= `RESEND_SETUP_RST;
      end else if (ce && wr_en && wr_addr == `RESEND_SETUP_OFS) begin
         resend_setup_ff <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         radio_channel_ff <= `RADIO_CHANNEL_RST;
      end else if (ce && wr_en && wr_addr == `RADIO_CHANNEL_SEL_OFS) begin
         radio_channel_ff <= wr_data[`CHAN_HI:`CHAN_LO];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         carrier_only_tx_ff <= `CARRIER_RST;
         low_rate_select_ff <= `LOW_RATE_RST;
         pll_lock_force_ff <= `PLL_FORCE_RST;
         high_rate_select_ff <= `HIGH_RATE_RST;
         tx_power_level_ff <= `PWR_RST;
      end else if (ce && wr_en && wr_addr == `RADIO_SETUP_OFS) begin
         carrier_only_tx_ff <= wr_data[`CARRIER_BIT];
         low_rate_select_ff <= wr_data[`LOW_RATE_BIT];
         pll_lock_force_ff <= wr_data[`PLL_FORCE_BIT];
         high_rate_select_ff <= wr_data[`HIGH_RATE_BIT];
         tx_power_level_ff <= wr_data[`PWR_HI:`PWR_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded settings to the radio

   logic [2:0] nxt_width;
   data_rate_t nxt_rate;

   // illegal width code keeps the last legal width rather than guess
   always_comb begin
      case (address_width_ff)
         `AW_3B: nxt_width = `WIDTH_3B;
         `AW_4B: nxt_width = `WIDTH_4B;
         `AW_5B: nxt_width = `WIDTH_5B;
         default: nxt_width = link_cfg.address_width;
      endcase
   end

   always_comb begin
      if (low_rate_select_ff) begin
         nxt_rate = RATE_250K;
      end else if (high_rate_select_ff) begin
         nxt_rate = RATE_2M;
      end else begin
         nxt_rate = RATE_1M;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         link_cfg.address_width <= `WIDTH_5B;
         link_cfg.addr_lane_en <= `LANES_5B;
      end else if (ce) begin
         link_cfg.address_width <= nxt_width;
         link_cfg.addr_lane_en <= lanes_of(nxt_width);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         link_cfg.radio_channel <= `RADIO_CHANNEL_RST;
         link_cfg.carrier_only_tx <= 1'b0;
         link_cfg.pll_lock_force <= 1'b0;
         link_cfg.data_rate <= RATE_2M;
         link_cfg.tx_power_level <= `PWR_RST;
      end else if (ce) begin
         link_cfg.radio_channel <= radio_channel_ff;
         link_cfg.carrier_only_tx <= carrier_only_tx_ff;
         link_cfg.pll_lock_force <= pll_lock_force_ff;
         link_cfg.data_rate <= nxt_rate;
         link_cfg.tx_power_level <= tx_power_level_ff;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         retransmit_limit <= `RLIMIT_RST;
         retransmit_delay <= `RDELAY_RST;
      end else if (ce) begin
         retransmit_limit <= resend_setup_ff[`RLIMIT_HI:`RLIMIT_LO];
         retransmit_delay <= resend_setup_ff[`RDELAY_HI:`RDELAY_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // retransmit timing and limit

   retransmit_ctrl #(
      .STEP_CYCLES(RETX_STEP_CYCLES)
   ) u_retx (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .retransmit_limit(resend_setup_ff[`RLIMIT_HI:`RLIMIT_LO]),
      .retransmit_delay(resend_setup_ff[`RDELAY_HI:`RDELAY_LO]),
      .packet_start(packet_start),
      .ack_missed(ack_missed),
      .ack_ok(ack_ok),
      .flag_clr(retry_flag_clr),
      .retx_start(retx_start),
      .retx_count(retx_count),
      .retry_exhausted_flag(retry_exhausted_flag),
      .retx_waiting(retx_waiting)
   );

endmodule : radio_link_setup_regs

/* File: bench/radio_link_setup_regs_monitor.sv */
`timescale 1ns/1ps
`include "radio_link_setup_defines.svh"

module radio_link_setup_regs_monitor
   import radio_link_setup_pkg::*;
#(
   parameter logic [19:0] RETX_STEP_CYCLES = 20'd50000
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // spi pins
   input wire logic spi_csn_b,
   input wire logic spi_miso_oe,
   // engine events
   input wire logic packet_start,
   input wire logic ack_missed,
   input wire logic retry_flag_clr,
   // settings and results
   input wire link_cfg_t link_cfg,
   input wire logic [3:0] retransmit_limit,
   input wire logic retx_start,
   input wire logic [3:0] retx_count,
   input wire logic retry_exhausted_flag,
   input wire logic retx_waiting
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   logic miss_ok;
   assign miss_ok = ack_missed && ce && !retry_exhausted_flag;

   property p_flag_set;
      miss_ok && retx_count >= retransmit_limit |=> retry_exhausted_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("retry flag not raised at limit");
   property p_flag_hold;
      retry_exhausted_flag && !retry_flag_clr |=> retry_exhausted_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("retry flag dropped without clear");
   property p_flag_clr;
      retry_exhausted_flag && retry_flag_clr && ce |=> !retry_exhausted_flag;
   endproperty
   a_flag_clr: assert property (p_flag_clr)
      else $error("retry flag not cleared");
   property p_count_inc;
      miss_ok && !packet_start && retx_count < retransmit_limit
         |=> retx_count == $past(retx_count) + 4'h1;
   endproperty
   a_count_inc: assert property (p_count_inc)
      else $error("retry count did not step");
   property p_count_clr;
      packet_start && ce && !ack_missed |=> retx_count == 4'h0;
   endproperty
   a_count_clr: assert property (p_count_clr)
      else $error("retry count not cleared");
   property p_start_once;
      retx_start |=> !retx_start;
   endproperty
   a_start_once: assert property (p_start_once)
      else $error("retransmit start longer than a cycle");
   // minimum wait is one step, ten cycles here, above eight
   property p_start_late;
      $rose(retx_waiting) |-> !retx_start [*8];
   endproperty
   a_start_late: assert property (p_start_late)
      else $error("retransmit started too early");
   property p_lane_map;
      (link_cfg.address_width == 3'h3 && link_cfg.addr_lane_en == `LANES_3B)
      || (link_cfg.address_width == 3'h4
          && link_cfg.addr_lane_en == `LANES_4B)
      || (link_cfg.address_width == 3'h5
          && link_cfg.addr_lane_en == `LANES_5B);
   endproperty
   a_lane_map: assert property (p_lane_map)
      else $error("address width and byte lanes disagree");
   property p_rate_legal;
      link_cfg.data_rate != 2'h3;
   endproperty
   a_rate_legal: assert property (p_rate_legal)
      else $error("reserved data rate on output");
   property p_oe_idle;
      spi_csn_b [*6] |-> !spi_miso_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("miso driven while deselected");
   property p_oe_frame;
      !spi_csn_b [*6] |-> spi_miso_oe;
   endproperty
   a_oe_frame: assert property (p_oe_frame)
      else $error("miso not driven in frame");
   property p_cfg_quiet;
      spi_csn_b [*8] |-> $stable(link_cfg) && $stable(retransmit_limit);
   endproperty
   a_cfg_quiet: assert property (p_cfg_quiet)
      else $error("settings changed without a frame");
endmodule : radio_link_setup_regs_monitor

bind radio_link_setup_regs radio_link_setup_regs_monitor #(
   .RETX_STEP_CYCLES(RETX_STEP_CYCLES)
) mon (.clock, .rst_b, .ce, .spi_csn_b, .spi_miso_oe, .packet_start,
   .ack_missed, .retry_flag_clr, .link_cfg, .retransmit_limit,
   .retx_start, .retx_count, .retry_exhausted_flag, .retx_waiting);

/* File: bench/mcu_spi_model.sv */
`timescale 1ns/1ps

module mcu_spi_model #(
   parameter int HALF = 8
) (
   // clock reference
   input wire logic clock,
   // spi pins
   output logic spi_sck,
   output logic spi_csn_b,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sck = 1'b0;
      spi_csn_b = 1'b1;
      spi_mosi = 1'b0;
   end

   // mode 0 frame: command byte then one data byte, msb first
   // half period of 8 clocks covers the 3-clock miso latency
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat,
         output logic [7:0] stat, output logic [7:0] rdat);
      logic [15:0] sh;
      logic [15:0] got;
      sh = {cmd, wdat};
      @(posedge clock);
      #1 spi_csn_b = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi = sh[i];
         repeat (HALF) @(posedge clock);
         #1 spi_sck = 1'b1;
         got[i] = spi_miso;
         repeat (HALF) @(posedge clock);
         #1 spi_sck = 1'b0;
      end
      repeat (HALF) @(posedge clock);
      #1 spi_csn_b = 1'b1;
      // released line must not keep showing the last bit
      spi_mosi = ~spi_mosi;
      repeat (2 * HALF) @(posedge clock);
      stat = got[15:8];
      rdat = got[7:0];
   endtask : xfer
endmodule : mcu_spi_model

/* File: bench/radio_link_setup_regs_tb.sv */
`timescale 1ns/1ps

module radio_link_setup_regs_tb
   import radio_link_setup_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b;
   logic ce;
   logic [3:0] ev;
   wire logic spi_sck, spi_csn_b, spi_mosi, spi_miso, spi_miso_oe;
   link_cfg_t link_cfg;
   logic [3:0] retransmit_limit, retransmit_delay, retx_count;
   logic retx_start, retry_exhausted_flag, retx_waiting;
   logic [7:0] st, rd, v, exp_rate;
   logic [7:0] rst_tab [5] = '{8'h03, 8'h03, 8'h02, 8'h0E, 8'h00};
   logic [3:0] dly_tab [3] = '{4'h0, 4'h5, 4'hF};
   int mismatches = 0;
   int n_compared = 0;
   int n;

   always #2.5 clock = ~clock;

   radio_link_setup_regs #(.RETX_STEP_CYCLES(20'h0000A)) dut (
      .clock(clock), .rst_b(rst_b), .ce(ce),
      .spi_sck(spi_sck), .spi_csn_b(spi_csn_b), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .packet_start(ev[0]), .ack_missed(ev[1]), .ack_ok(ev[2]),
      .retry_flag_clr(ev[3]), .link_cfg(link_cfg),
      .retransmit_limit(retransmit_limit),
      .retransmit_delay(retransmit_delay), .retx_start(retx_start),
      .retx_count(retx_count), .retry_exhausted_flag(retry_exhausted_flag),
      .retx_waiting(retx_waiting));

   mcu_spi_model mcu (.clock(clock), .spi_sck(spi_sck),
      .spi_csn_b(spi_csn_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   ////////////////////////////////////////////////////////////////////////
   task final_report;
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task check(input string name, input logic [7:0] seen,
         input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [7:0] d);
      mcu.xfer(8'h20 | a, d, st, rd);
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [7:0] exp);
      mcu.xfer(a, 8'h00, st, rd);
      check("readback", rd, exp);
   endtask : rdchk

   task ev_pulse(input logic [3:0] p);
      @(posedge clock);
      #1 ev = p;
      @(posedge clock);
      #1 ev = 4'h0;
   endtask : ev_pulse

   // cycles from the edge taking ack_missed to the start pulse
   task wait_start;
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (retx_start !== 1'b1 && n < 400);
      if (n >= 400) begin
         mismatches++;
         final_report;
      end
   endtask : wait_start

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      ev = 4'h0;
      ce = 1'b1;
      repeat (6) @(posedge clock);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 5; i++) rdchk(8'(i + 3), rst_tab[i]);
      check("width", 8'(link_cfg.address_width), 8'h05);
      check("channel", 8'(link_cfg.radio_channel), 8'h02);
      check("rate", 8'(link_cfg.data_rate), 8'h01);
      check("power", 8'(link_cfg.tx_power_level), 8'h03);
      check("carrier", 8'(link_cfg.carrier_only_tx), 8'h00);
      check("limit", 8'(retransmit_limit), 8'h03);
      for (int i = 1; i < 4; i++) begin
         wr(8'h03, 8'(i));
         rdchk(8'h03, 8'(i));
         check("width", 8'(link_cfg.address_width), 8'(i + 2));
         check("lanes", 8'(link_cfg.addr_lane_en), 8'h1F >> (3 - i));
      end
      wr(8'h03, 8'h00);
      rdchk(8'h03, 8'h00);
      check("width", 8'(link_cfg.address_width), 8'h05);
      wr(8'h05, 8'h7F);
      rdchk(8'h05, 8'h7F);
      check("channel", 8'(link_cfg.radio_channel), 8'h7F);
      foreach (rst_tab[i]) begin
         v = (i == 0) ? 8'hBE : (i == 1) ? 8'h0A : (i == 2) ? 8'h24 : 8'h00;
         exp_rate = v[5] ? 8'h02 : {7'h00, v[3]};
         wr(8'h06, v);
         rdchk(8'h06, v & 8'hBE);
         check("carrier", 8'(link_cfg.carrier_only_tx), 8'(v[7]));
         check("pll", 8'(link_cfg.pll_lock_force), 8'(v[4]));
         check("power", 8'(link_cfg.tx_power_level), 8'(v[2:1]));
         check("rate", 8'(link_cfg.data_rate), exp_rate);
      end
      foreach (dly_tab[i]) begin
         wr(8'h04, {dly_tab[i], 4'hF});
         check("delay", 8'(retransmit_delay), 8'(dly_tab[i]));
         ev_pulse(4'h1);
         ev_pulse(4'h2);
         wait_start;
         check("retx time", 8'(n), 8'((dly_tab[i] + 1) * 10));
         check("count", 8'(retx_count), 8'h01);
      end
      wr(8'h04, 8'h02);
      ev_pulse(4'h1);
      for (int k = 1; k < 3; k++) begin
         ev_pulse(4'h2);
         wait_start;
         check("count", 8'(retx_count), 8'(k));
      end
      ev_pulse(4'h2);
      check("flag", 8'(retry_exhausted_flag), 8'h01);
      rdchk(8'h04, 8'h02);
      check("status", st, 8'h10);
      ev_pulse(4'h2);
      check("count", 8'(retx_count), 8'h02);
      ev_pulse(4'h8);
      check("flag", 8'(retry_exhausted_flag), 8'h00);
      ev_pulse(4'h1);
      check("count", 8'(retx_count), 8'h00);
      wr(8'h04, 8'h30);
      ev_pulse(4'h2);
      check("flag", 8'(retry_exhausted_flag), 8'h01);
      ev_pulse(4'h8);
      wr(8'h04, 8'h01);
      ev_pulse(4'h1);
      ev_pulse(4'h2);
      ev_pulse(4'h4);
      n = 0;
      repeat (40) begin
         @(posedge clock);
         #1 n += int'(retx_start === 1'b1);
      end
      check("cancel", 8'(n), 8'h00);
      // enable low must freeze the count against a packet start
      ce = 1'b0;
      ev_pulse(4'h1);
      check("frozen", 8'(retx_count), 8'h01);
      ce = 1'b1;
      @(posedge clock);
      #1 rst_b = 1'b0;
      repeat (3) @(posedge clock);
      #1 rst_b = 1'b1;
      rdchk(8'h05, 8'h02);
      final_report;
   end
endmodule : radio_link_setup_regs_tb
